/* rtl/rss_pkg.sv */
package rss_pkg;
   localparam int NRAIL = 7;
   // Rail order: buck a, buck b, buck c, standby a, standby b,
   // switch a, switch b
   localparam logic [NRAIL-1:0] RAILS_BUCK = 7'h07;
   localparam logic [NRAIL-1:0] RAILS_STANDBY = 7'h18;
   localparam int TW = 14;
   localparam logic [3:0] STB_NONE = 4'h0;
   localparam logic [3:0] STB_FIRST = 4'h1;
   localparam logic [3:0] STB_LAST = 4'h7;
   localparam logic [3:0] STB_SP_A = 4'he;
   localparam logic [3:0] STB_SP_B = 4'hf;
   localparam logic [2:0] SLOT_LAST = 3'h6;
   localparam logic [3:0] DLY_CODE_MAX = 4'h9;
   localparam logic [TW-1:0] MS_DLY_MAX = 14'h000a;
   localparam logic [TW-1:0] MS_EN_WINDOW = 14'h1388;
   localparam logic [TW-1:0] MS_LONG_PRESS = 14'h1f40;
   localparam logic [TW-1:0] MS_SLEEP_WAIT = 14'h03e8;
   localparam logic [TW-1:0] MS_RESET_MIN = 14'h03e8;
   localparam logic [5:0] MS_DEGLITCH = 6'h32;
   localparam logic [2:0] MS_MON_START = 3'h5;
   localparam int CLK_HZ = 100000000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // Strobe per rail, rail 6 in the top nibble
   localparam logic [4*NRAIL-1:0] STB_DEF = 28'h54fe321;
   // Delay codes for slots 1 to 6; code n means n+1 ms up to code 9, codes above 9 mean 10 ms
   localparam logic [23:0] DLY_DEF = 24'h111111;
   localparam logic [1:0] MASK_DEF = 2'h3;
   localparam logic [7:0] GDLY_DEF = 8'h14;

   typedef enum logic [7:0] {
      ST_OFF = 8'h01,
      ST_WAIT = 8'h02,
      ST_UP = 8'h04,
      ST_ACTIVE = 8'h08,
      ST_DOWN = 8'h10,
      ST_SLEEPWAIT = 8'h20,
      ST_SLEEP = 8'h40,
      ST_RESET = 8'h80
   } rss_state_e;

   typedef enum logic [2:0] {
      TGT_OFF = 3'h1,
      TGT_SLEEP = 3'h2,
      TGT_RESET = 3'h4
   } rss_target_e;

   typedef struct packed {
      logic stb_wr;
      logic [2:0] stb_rail;
      logic [3:0] stb_val;
      logic dly_wr;
      logic [2:0] dly_slot;
      logic [3:0] dly_val;
      logic en_wr;
      logic [NRAIL-1:0] en_val;
      logic mask_wr;
      logic [1:0] mask_val;
      logic gdly_wr;
      logic [7:0] gdly_val;
   } rss_cfg_s;
endpackage

/* rtl/rss_ms_timer.sv */
`timescale 1ns/1ps
module rss_ms_timer import rss_pkg::*; (
   input wire logic clock, // System clock
   input wire logic rst_n, // Asynchronous reset
   input wire logic tick, // One-cycle millisecond tick
   input wire logic start, // Load a new count
   input wire logic [TW-1:0] load, // Count in milliseconds
   output logic expired // Count has run out
);
   logic [TW-1:0] cnt_reg;
   logic [TW-1:0] cnt_next;

   assign expired = (cnt_reg == '0);
   assign cnt_next = start ? load :
      ((tick && !expired) ? cnt_reg - 14'h0001 : cnt_reg);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

/* rtl/rss_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Rails tied to strobes; delays 1 to 10 ms
// - Configuration restored on sleep, off, reset
// - Power-up fires strobe 1, then delays onward
// - One strobe per rail; shared strobes allowed
// - Wake from off needs event and no lockout
// - Enable is a level; 5 s window
// - In sleep, enable alone starts power-up
// - Up trigger runs sequencer, self-clears when done
// - Strobe 0 rails untouched by sequencing
// - Enable writes refused while sequencer runs
// - Enable bits mirror true rail state
// - Power-down runs strobe 7 back to 1
// - Immediate shutdown skips all down delays
// - Listed events start power-down
// - Unsequenced rails off only when going off or to reset
// - Strobe 14 on wake, 15 after slot 6
// - Down fires 15, 14 only with off-select
// - Failing good signal shuts all rails off
// - Monitoring starts 5 ms after rail enable
// - Main good waits sequencer done plus delay; standby good also set in sleep
// - Main good covers bucks, regulators, unmasked standby
// - Button deglitched 50 ms; change flag, level
// - Off-select picks off or sleep on drop
// - Sleep entry waits 1 s after shutdown
module rss_sequencer import rss_pkg::*; #(
   parameter int MS_CYCLES = CYC_PER_MS // Clock cycles per ms
) (
   input wire logic clock, // 100 MHz clock
   input wire logic rst_n, // Asynchronous reset
   input wire logic power_enable_pin, // Host power enable level
   input wire logic push_button_input_n, // Button, low when pressed
   input wire logic hard_reset_input_n, // Reset pin, low active
   input wire logic usb_supply, // USB supply present
   input wire logic ac_supply, // AC supply present
   input wire logic undervoltage_lockout, // Lockout condition
   input wire logic overtemp_shutdown, // Thermal shutdown
   input wire logic [NRAIL-1:0] rail_good, // Deglitched good per rail
   input wire logic [1:0] switch_regulator_mode, // Switch a/b as regulator
   input wire logic off_select, // 1: drop goes to off
   input wire logic immediate_shutdown_bit, // Skip down delays
   input wire logic sequence_up_set, // Pulse: request power-up
   input wire logic sequence_down_trigger, // Pulse: request power-down
   input wire logic button_flag_clear, // Pulse: clear change flag
   input wire rss_cfg_s cfg, // Configuration writes
   output logic [NRAIL-1:0] rail_enable, // Rail enables
   output logic main_rails_good, // Main good output
   output logic standby_rails_good, // Standby good output
   output logic button_change_flag, // Sticky button change
   output logic button_level_status, // Deglitched level, 1 pressed
   output logic sequence_up_trigger, // Up request pending
   output logic sequencer_busy, // Sequencer running
   output rss_state_e power_state // Present power state
);
   localparam logic [16:0] PRE_LAST = 17'(MS_CYCLES - 1);

   function automatic logic [NRAIL-1:0] rails_at(
      input logic [4*NRAIL-1:0] map, input logic [3:0] s);
      logic [NRAIL-1:0] r;
      r = '0;
      for (int i = 0; i < NRAIL; i++) begin
         r[i] = (map[4*i +: 4] == s);
      end
      return r;
   endfunction

   function automatic logic [NRAIL-1:0] rails_seq(
      input logic [4*NRAIL-1:0] map);
      logic [NRAIL-1:0] r;
      r = '0;
      for (int i = 0; i < NRAIL; i++) begin
         r[i] = (map[4*i +: 4] >= STB_FIRST) &&
            (map[4*i +: 4] <= STB_LAST);
      end
      return r;
   endfunction

   // Delay in ms for slot s (1 to 6); codes saturate at 10 ms
   function automatic logic [TW-1:0] slot_ms(
      input logic [23:0] map, input logic [2:0] s);
      logic [3:0] c;
      c = map[4*(s-3'h1) +: 4];
      if (c >= DLY_CODE_MAX) begin
         return MS_DLY_MAX;
      end
      return TW'(c) + 14'h0001;
   endfunction

   rss_state_e st_reg, st_next;
   rss_target_e tgt_reg, tgt_next;
   logic [16:0] pre_reg;
   logic tick_reg, busy_reg;
   logic [4*NRAIL-1:0] stb_reg;
   logic [23:0] dly_reg;
   logic [1:0] mask_reg;
   logic [7:0] gdly_reg;
   logic [3:0] cur_reg, cur_next;
   logic [NRAIL-1:0] en_reg, en_next;
   logic up_reg, up_next;
   logic gwait_reg, gwait_next;
   logic good_ok_reg;
   logic sp_pend_reg;
   logic usb_prev_reg, ac_prev_reg;
   logic [5:0] pb_cnt_reg;
   logic pb_reg;
   logic lp_arm_reg;
   logic chg_reg;
   logic main_good_reg, sb_good_reg;
   logic [2:0] mon_reg [NRAIL];
   logic tmr_go, sp_go, go_up, go_down, finish;
   logic [TW-1:0] tmr_load;
   rss_target_e down_tgt;
   logic [NRAIL-1:0] down_rails;

   wire busy = (st_reg == ST_UP) || (st_reg == ST_DOWN);
   wire pb_flip = (~push_button_input_n != pb_reg) && tick_reg &&
      (pb_cnt_reg == MS_DEGLITCH - 6'h01);
   wire pb_press = pb_flip && !pb_reg;
   wire wake_evt = pb_press || (usb_supply && !usb_prev_reg) ||
      (ac_supply && !ac_prev_reg);
   wire lockout = undervoltage_lockout || overtemp_shutdown;
   wire wake_ok = wake_evt && !lockout;
   wire tmr_exp, sp_exp, lp_exp;
   wire long_fire = pb_reg && lp_arm_reg && lp_exp;
   wire rst_req = !hard_reset_input_n || long_fire;
   wire drop_req = !power_enable_pin || sequence_down_trigger;
   wire [NRAIL-1:0] sw_watch = {switch_regulator_mode, 5'h1f};
   wire [NRAIL-1:0] main_set = {switch_regulator_mode, ~mask_reg,
      RAILS_BUCK[2:0]};
   wire [NRAIL-1:0] armed;
   wire pg_fail = |(armed & ~rail_good & sw_watch & en_reg);
   wire fault = (lockout || pg_fail) && (st_reg != ST_OFF);
   wire off_tgt_sel = off_select;
   wire sp_off = off_select;
   wire good_set = (st_reg == ST_ACTIVE) && gwait_reg && tmr_exp;
   wire good_clr = (st_reg == ST_OFF) || (st_reg == ST_WAIT) ||
      (st_reg == ST_RESET) || (st_reg == ST_UP);
   wire enter_rst = (st_next != st_reg) && ((st_next == ST_OFF) ||
      (st_next == ST_SLEEP) || (st_next == ST_RESET));
   wire stb_ok = (cfg.stb_val < STB_SP_A) ||
      (cfg.stb_rail == 3'h3) || (cfg.stb_rail == 3'h4);
   wire slot_ok = (cfg.dly_slot != 3'h0) && (cfg.dly_slot <= SLOT_LAST);

   genvar g;
   for (g = 0; g < NRAIL; g++) begin : g_mon
      assign armed[g] = (mon_reg[g] == MS_MON_START);
   end

   rss_ms_timer u_main_tmr (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_reg),
      .start(tmr_go),
      .load(tmr_load),
      .expired(tmr_exp)
   );

   rss_ms_timer u_sp_tmr (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_reg),
      .start(sp_go),
      .load(slot_ms(dly_reg, SLOT_LAST)),
      .expired(sp_exp)
   );

   rss_ms_timer u_lp_tmr (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_reg),
      .start(pb_press || long_fire),
      .load(MS_LONG_PRESS),
      .expired(lp_exp)
   );

   always_comb begin
      st_next = st_reg;
      tgt_next = tgt_reg;
      cur_next = cur_reg;
      en_next = en_reg;
      up_next = up_reg;
      gwait_next = gwait_reg;
      tmr_go = 1'b0;
      tmr_load = '0;
      sp_go = 1'b0;
      go_up = 1'b0;
      go_down = 1'b0;
      finish = 1'b0;
      down_tgt = off_tgt_sel ? TGT_OFF : TGT_SLEEP;
      down_rails = rails_at(stb_reg, cur_reg);
      if (immediate_shutdown_bit) begin
         down_rails = rails_seq(stb_reg) |
            (sp_off ? RAILS_STANDBY & ~rails_at(stb_reg, STB_NONE) :
            '0);
      end
      if (sequence_up_set && st_reg == ST_ACTIVE) begin
         up_next = 1'b1;
      end
      if (cfg.en_wr && !busy) begin
         en_next = cfg.en_val;
      end
      if (sp_pend_reg && sp_exp) begin
         en_next = en_next | rails_at(stb_reg, STB_SP_B);
      end
      if (good_set) begin
         gwait_next = 1'b0;
      end
      unique case (st_reg)
         ST_OFF, ST_SLEEP: begin
            if (wake_ok) begin
               st_next = ST_WAIT;
               tmr_go = 1'b1;
               tmr_load = MS_EN_WINDOW;
               en_next = en_next | rails_at(stb_reg, STB_SP_A);
               sp_go = 1'b1;
            end else if (st_reg == ST_SLEEP && power_enable_pin) begin
               go_up = 1'b1;
            end
         end
         ST_WAIT: begin
            if (power_enable_pin) begin
               go_up = 1'b1;
            end else if (tmr_exp) begin
               go_down = 1'b1;
            end
         end
         ST_ACTIVE: begin
            if (rst_req) begin
               go_down = 1'b1;
               down_tgt = TGT_RESET;
            end else if (drop_req) begin
               go_down = 1'b1;
            end else if (up_reg) begin
               go_up = 1'b1;
            end
         end
         ST_UP: begin
            if (rst_req) begin
               go_down = 1'b1;
               down_tgt = TGT_RESET;
            end else if (!power_enable_pin) begin
               go_down = 1'b1;
            end else if (tmr_exp) begin
               en_next = en_next | rails_at(stb_reg, cur_reg);
               tmr_go = 1'b1;
               if (cur_reg == STB_LAST) begin
                  st_next = ST_ACTIVE;
                  up_next = 1'b0;
                  gwait_next = 1'b1;
                  tmr_load = {6'h00, gdly_reg};
               end else begin
                  cur_next = cur_reg + 4'h1;
                  tmr_load = slot_ms(dly_reg, cur_reg[2:0]);
               end
            end
         end
         ST_DOWN: begin
            if (tmr_exp) begin
               en_next = en_next & ~down_rails;
               tmr_go = 1'b1;
               if (immediate_shutdown_bit) begin
                  finish = 1'b1;
               end else if (cur_reg == STB_SP_B) begin
                  cur_next = STB_SP_A;
                  tmr_load = slot_ms(dly_reg, SLOT_LAST);
               end else if (cur_reg == STB_SP_A) begin
                  finish = 1'b1;
               end else if (cur_reg == STB_FIRST) begin
                  if (sp_off) begin
                     cur_next = STB_SP_B;
                  end else begin
                     finish = 1'b1;
                  end
               end else begin
                  cur_next = cur_reg - 4'h1;
                  tmr_load = slot_ms(dly_reg, cur_next[2:0]);
               end
            end
         end
         ST_SLEEPWAIT: begin
            if (tmr_exp) begin
               st_next = ST_SLEEP;
            end
         end
         ST_RESET: begin
            if (tmr_exp && hard_reset_input_n) begin
               st_next = ST_WAIT;
               tmr_go = 1'b1;
               tmr_load = MS_EN_WINDOW;
               en_next = en_next | rails_at(stb_reg, STB_SP_A);
               sp_go = 1'b1;
            end
         end
         default: begin
            st_next = ST_OFF;
         end
      endcase
      if (finish) begin
         tmr_go = 1'b1;
         unique case (tgt_reg)
            TGT_OFF: begin
               st_next = ST_OFF;
               en_next = en_next & ~rails_at(stb_reg, STB_NONE);
            end
            TGT_SLEEP: begin
               st_next = ST_SLEEPWAIT;
               tmr_load = MS_SLEEP_WAIT;
            end
            default: begin
               st_next = ST_RESET;
               en_next = '0;
               tmr_load = MS_RESET_MIN;
            end
         endcase
      end
      if (go_down) begin
         st_next = ST_DOWN;
         tgt_next = down_tgt;
         cur_next = STB_LAST;
         tmr_go = 1'b1;
         tmr_load = '0;
      end else if (go_up) begin
         st_next = ST_UP;
         cur_next = STB_FIRST;
         tmr_go = 1'b1;
         tmr_load = '0;
      end
      if (fault) begin
         st_next = ST_OFF;
         en_next = '0;
         gwait_next = 1'b0;
         up_next = 1'b0;
      end
   end

   // Millisecond tick shared by every timer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         pre_reg <= (pre_reg == PRE_LAST) ? '0 : pre_reg + 17'h00001;
         tick_reg <= (pre_reg == PRE_LAST);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_OFF;
         tgt_reg <= TGT_OFF;
         cur_reg <= STB_NONE;
         en_reg <= '0;
         up_reg <= 1'b0;
         gwait_reg <= 1'b0;
         sp_pend_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         tgt_reg <= tgt_next;
         cur_reg <= cur_next;
         en_reg <= en_next;
         up_reg <= up_next;
         gwait_reg <= gwait_next;
         sp_pend_reg <= !fault && (sp_go || (sp_pend_reg && !sp_exp));
         busy_reg <= st_next inside {ST_UP, ST_DOWN};
      end
   end

   // Configuration falls back to defaults on each low-power entry
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stb_reg <= STB_DEF;
         dly_reg <= DLY_DEF;
         mask_reg <= MASK_DEF;
         gdly_reg <= GDLY_DEF;
      end else if (enter_rst) begin
         stb_reg <= STB_DEF;
         dly_reg <= DLY_DEF;
         mask_reg <= MASK_DEF;
         gdly_reg <= GDLY_DEF;
      end else begin
         if (cfg.stb_wr && stb_ok && cfg.stb_rail < 3'(NRAIL)) begin
            stb_reg[4*cfg.stb_rail +: 4] <= cfg.stb_val;
         end
         if (cfg.dly_wr && slot_ok) begin
            dly_reg[4*(cfg.dly_slot-3'h1) +: 4] <= cfg.dly_val;
         end
         if (cfg.mask_wr) begin
            mask_reg <= cfg.mask_val;
         end
         if (cfg.gdly_wr) begin
            gdly_reg <= cfg.gdly_val;
         end
      end
   end

   // Button deglitch; the long-press timer restarts every 8 s held
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pb_cnt_reg <= '0;
         pb_reg <= 1'b0;
         lp_arm_reg <= 1'b0;
         chg_reg <= 1'b0;
         usb_prev_reg <= 1'b0;
         ac_prev_reg <= 1'b0;
      end else begin
         usb_prev_reg <= usb_supply;
         ac_prev_reg <= ac_supply;
         if (~push_button_input_n == pb_reg || pb_flip) begin
            pb_cnt_reg <= '0;
         end else if (tick_reg) begin
            pb_cnt_reg <= pb_cnt_reg + 6'h01;
         end
         if (pb_flip) begin
            pb_reg <= !pb_reg;
         end
         lp_arm_reg <= pb_press || (lp_arm_reg && pb_reg);
         chg_reg <= pb_flip || (chg_reg && !button_flag_clear);
      end
   end

   // Per-rail good monitor arms 5 ms after enable
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NRAIL; i++) begin
            mon_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NRAIL; i++) begin
            if (!en_reg[i]) begin
               mon_reg[i] <= '0;
            end else if (tick_reg && mon_reg[i] != MS_MON_START) begin
               mon_reg[i] <= mon_reg[i] + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         good_ok_reg <= 1'b0;
         main_good_reg <= 1'b0;
         sb_good_reg <= 1'b0;
      end else begin
         good_ok_reg <= !fault && !good_clr && (good_ok_reg || good_set);
         main_good_reg <= good_ok_reg && (st_reg == ST_ACTIVE) &&
            |(en_reg & main_set) && !pg_fail;
         sb_good_reg <= (good_ok_reg || st_reg == ST_SLEEP) &&
            |(en_reg & RAILS_STANDBY) && !pg_fail;
      end
   end

   assign rail_enable = en_reg;
   assign main_rails_good = main_good_reg;
   assign standby_rails_good = sb_good_reg;
   assign button_change_flag = chg_reg;
   assign button_level_status = pb_reg;
   assign sequence_up_trigger = up_reg;
   assign sequencer_busy = busy_reg;
   assign power_state = st_reg;
endmodule

/* tb/rss_sequencer_sva.sv */
`timescale 1ns/1ps
module rss_sequencer_sva import rss_pkg::*; #(
   parameter int MS_CYCLES = CYC_PER_MS // Cycles per ms
) (
   input wire logic clock, // Clock
   input wire logic rst_n, // Reset
   input wire logic power_enable_pin, // Enable level
   input wire logic push_button_input_n, // Button
   input wire logic hard_reset_input_n, // Reset pin
   input wire logic usb_supply, // USB present
   input wire logic undervoltage_lockout, // Lockout
   input wire logic overtemp_shutdown, // Thermal
   input wire logic [NRAIL-1:0] rail_enable, // Rails
   input wire logic main_rails_good, // Main good
   input wire logic standby_rails_good, // Standby good
   input wire logic button_change_flag, // Change flag
   input wire logic button_level_status, // Button level
   input wire logic sequence_up_trigger, // Up pending
   input wire rss_state_e power_state // State
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   int act_cnt;
   int pb_cnt;
   // Cycles spent in active, and since the raw button last moved
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         act_cnt <= 0;
         pb_cnt <= 0;
      end else begin
         act_cnt <= (power_state == ST_ACTIVE) ? act_cnt + 1 : 0;
         pb_cnt <= $changed(push_button_input_n) ? 0 : pb_cnt + 1;
      end
   end
   chk_wake_to_wait: assert property (
      power_state == ST_OFF && $rose(usb_supply) && hard_reset_input_n &&
      !undervoltage_lockout && !overtemp_shutdown
      |=> power_state == ST_WAIT && rail_enable[3])
      else $error("wake from off not taken");
   chk_sleep_wakes: assert property (
      power_state == ST_SLEEP && power_enable_pin && hard_reset_input_n &&
      !undervoltage_lockout && !overtemp_shutdown |=> power_state == ST_UP)
      else $error("enable did not leave sleep");
   chk_up_first: assert property (
      power_state == ST_UP && $past(power_state) inside {ST_WAIT, ST_SLEEP}
      |=> rail_enable[0] && !rail_enable[1])
      else $error("first strobe wrong");
   chk_down_order: assert property (
      $fell(rail_enable[0]) && power_state == ST_DOWN
      |-> !rail_enable[5] && !rail_enable[2])
      else $error("down order wrong");
   chk_fault_off: assert property (
      undervoltage_lockout |=> power_state == ST_OFF && rail_enable == 7'h00)
      else $error("lockout did not shut down");
   chk_no_rail_good: assert property (
      rail_enable == 7'h00 [*3] |-> !main_rails_good && !standby_rails_good)
      else $error("good high with no rail");
   chk_good_delay: assert property (
      $rose(main_rails_good) |-> power_state == ST_ACTIVE &&
      act_cnt >= 19 * MS_CYCLES)
      else $error("main good too early");
   chk_good_low_idle: assert property (
      power_state inside {ST_SLEEP, ST_WAIT} |-> !main_rails_good)
      else $error("main good high when idle");
   chk_up_clears: assert property (
      $rose(power_state == ST_ACTIVE) |-> ##[0:1] !sequence_up_trigger)
      else $error("up request not cleared");
   chk_button_glitch: assert property (
      $changed(button_level_status)
      |-> (pb_cnt >= 49 * MS_CYCLES) ##[0:1] button_change_flag)
      else $error("button level not deglitched");
   cov_good: cover property ($rose(main_rails_good));
   cov_sleep: cover property (power_state == ST_SLEEP);
   cov_down: cover property ($fell(rail_enable[0]) && power_state == ST_DOWN);
endmodule

bind rss_sequencer rss_sequencer_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (
   .clock, .rst_n, .power_enable_pin, .push_button_input_n,
   .hard_reset_input_n, .usb_supply, .undervoltage_lockout,
   .overtemp_shutdown, .rail_enable, .main_rails_good, .standby_rails_good,
   .button_change_flag, .button_level_status, .sequence_up_trigger,
   .power_state);

/* tb/rss_host_model.sv */
`timescale 1ns/1ps
module rss_host_model (
   input wire logic clock, // Clock
   input wire logic rst_n, // Reset
   input wire logic want_on, // Bench asks for power
   input wire logic [7:0] lag, // Reply delay in cycles
   output logic power_enable_pin // Level to the device
);
   logic [7:0] wait_reg;
   // A host answers late but always far inside the enable window
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 8'h00;
         power_enable_pin <= 1'b0;
      end else if (want_on == power_enable_pin) begin
         wait_reg <= 8'h00;
      end else if (wait_reg >= lag) begin
         power_enable_pin <= want_on;
      end else begin
         wait_reg <= wait_reg + 8'h01;
      end
   end
endmodule

/* tb/rail_strobe_sequencer_test.sv */
`timescale 1ns/1ps
module rail_strobe_sequencer_test import rss_pkg::*; ;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic push_button_input_n = 1'b1;
   logic usb_supply = 1'b0;
   logic ac_supply = 1'b0;
   logic undervoltage_lockout = 1'b0;
   logic [NRAIL-1:0] rail_good = 7'h00;
   logic [NRAIL-1:0] bad_rails = 7'h00;
   logic off_select = 1'b0;
   logic immediate_shutdown_bit = 1'b0;
   logic sequence_up_set = 1'b0;
   logic button_flag_clear = 1'b0;
   rss_cfg_s cfg = '0;
   logic want_on = 1'b0;
   logic [7:0] lag = 8'h00;
   logic power_enable_pin;
   logic [NRAIL-1:0] rail_enable;
   logic main_rails_good, standby_rails_good, button_change_flag;
   logic button_level_status, sequence_up_trigger, sequencer_busy;
   rss_state_e power_state;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   int i;

   rss_host_model host_u (.clock, .rst_n, .want_on, .lag, .power_enable_pin);
   rss_sequencer #(.MS_CYCLES(10)) dut_u (.clock, .rst_n, .power_enable_pin,
      .push_button_input_n, .hard_reset_input_n(1'b1), .usb_supply,
      .ac_supply, .undervoltage_lockout, .overtemp_shutdown(1'b0),
      .rail_good, .switch_regulator_mode(2'h3), .off_select,
      .immediate_shutdown_bit, .sequence_up_set,
      .sequence_down_trigger(1'b0), .button_flag_clear, .cfg, .rail_enable,
      .main_rails_good, .standby_rails_good, .button_change_flag,
      .button_level_status, .sequence_up_trigger, .sequencer_busy,
      .power_state);

   initial begin
      forever #5 clock = ~clock;
   end
   // Rails report good while enabled unless the bench breaks one
   always @(posedge clock) rail_good <= rail_enable & ~bad_rails;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         test_done;
      end
   end

   task automatic test_done;
      if (fails == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_st(input rss_state_e s);
      for (i = 0; i < 15000 && power_state !== s; i++) @(negedge clock);
      chk("power_state", s, power_state);
   endtask
   task automatic wait_busy;
      for (i = 0; i < 400 && sequencer_busy !== 1'b1; i++) @(negedge clock);
   endtask
   // Rails left after enable drops: standby and unsequenced ones survive into sleep, none into off
   function automatic logic [7:0] after_drop(input logic to_off,
                                             input logic [6:0] unseq);
      return to_off ? 8'h00 : {1'b0, 7'h7f & (RAILS_STANDBY | unseq)};
   endfunction

   initial begin
      void'($urandom(89237));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      chk("rail_enable", 8'h00, {1'b0, rail_enable});
      chk("power_state", ST_OFF, power_state);
      @(posedge clock);
      lag <= 8'($urandom_range(200, 10));
      want_on <= 1'b1;
      push_button_input_n <= 1'b0;
      repeat (600) @(posedge clock);
      push_button_input_n <= 1'b1;
      @(negedge clock);
      chk("button_level", 8'h01, {7'h00, button_level_status});
      wait_st(ST_ACTIVE);
      chk("rail_enable", 8'h7f, {1'b0, rail_enable});
      for (i = 0; i < 400 && main_rails_good !== 1'b1; i++) @(negedge clock);
      chk("good_delay", 8'h01, {7'h00, i >= 180 && i <= 220});
      chk("standby_good", 8'h01, {7'h00, standby_rails_good});
      repeat (500) @(posedge clock);
      button_flag_clear <= 1'b1;
      cfg.stb_wr <= 1'b1;
      cfg.stb_rail <= 3'h6;
      cfg.stb_val <= STB_NONE;
      @(posedge clock);
      button_flag_clear <= 1'b0;
      cfg.stb_wr <= 1'b0;
      want_on <= 1'b0;
      @(negedge clock);
      chk("button_flag", 8'h00, {7'h00, button_change_flag});
      wait_busy;
      @(posedge clock);
      cfg.en_wr <= 1'b1;
      cfg.en_val <= 7'h00;
      @(posedge clock);
      cfg.en_wr <= 1'b0;
      wait_st(ST_SLEEP);
      chk("rail_enable", after_drop(1'b0, 7'h40), {1'b0, rail_enable});
      chk("main_good", 8'h00, {7'h00, main_rails_good});
      @(posedge clock);
      want_on <= 1'b1;
      wait_st(ST_ACTIVE);
      chk("rail_enable", 8'h7f, {1'b0, rail_enable});
      @(posedge clock);
      sequence_up_set <= 1'b1;
      @(posedge clock);
      sequence_up_set <= 1'b0;
      wait_busy;
      chk("power_state", ST_UP, power_state);
      wait_st(ST_ACTIVE);
      chk("up_trigger", 8'h00, {7'h00, sequence_up_trigger});
      @(posedge clock);
      off_select <= 1'b1;
      immediate_shutdown_bit <= 1'b1;
      want_on <= 1'b0;
      wait_busy;
      repeat (2) @(negedge clock);
      chk("rail_enable", 8'h00, {1'b0, rail_enable & 7'h67});
      wait_st(ST_OFF);
      chk("rail_enable", after_drop(1'b1, 7'h00), {1'b0, rail_enable});
      @(posedge clock);
      off_select <= 1'b0;
      immediate_shutdown_bit <= 1'b0;
      usb_supply <= 1'b1;
      want_on <= 1'b1;
      wait_st(ST_ACTIVE);
      repeat (100) @(posedge clock);
      bad_rails <= 7'h01 << $urandom_range(2, 0);
      wait_st(ST_OFF);
      chk("rail_enable", 8'h00, {1'b0, rail_enable});
      chk("main_good", 8'h00, {7'h00, main_rails_good});
      @(posedge clock);
      bad_rails <= 7'h00;
      usb_supply <= 1'b0;
      undervoltage_lockout <= 1'b1;
      repeat (5) @(posedge clock);
      usb_supply <= 1'b1;
      ac_supply <= 1'b1;
      repeat (50) @(negedge clock);
      chk("power_state", ST_OFF, power_state);
      test_done;
   end
endmodule
